// File: hdl/tsw_config_regs.sv
// configuration register bank of the four-source serial switch
`timescale 1ns/1ps
`default_nettype none
module tsw_config_regs
    import tsw_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,

    // strap pins, asynchronous to clk_i
    input  wire tsw_strap_t strap_pins_i,

    // register port from the serial control front end
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [2:0] reg_idx_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_rvalid_o,

    // high speed switch controls
    output logic            hs_switch_en_o,
    output logic      [1:0] hs_mode_o,
    output logic      [3:0] hs_source_sel_o,
    output logic            standby_o,

    // auxiliary switch controls
    output logic            aux_switch_en_o,
    output logic      [1:0] aux_mode_o,
    output logic      [3:0] aux_source_sel_o,

    // receive side, one bit per input channel
    output logic     [15:0] input_term_conn_o,
    output logic     [15:0] input_eq_level_o,

    // transmit side, shared by all outputs
    output logic      [1:0] out_preemph_level_o,
    output logic            out_term_on_o,
    output logic            out_current_sel_o,

    // control source status
    output logic            pin_ctrl_o
);

    typedef struct packed {
        tsw_regs_t   regs;
        logic        pin_ctrl;
        logic [3:0]  src_prev;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        hs_en;
        logic [1:0]  hs_mode;
        logic [3:0]  hs_src;
        logic        standby;
        logic        aux_en;
        logic [1:0]  aux_mode;
        logic [3:0]  aux_src;
        logic [15:0] term_conn;
        logic [15:0] eq_level;
        logic [1:0]  preemph;
        logic        out_term;
        logic        out_cur;
    } tsw_state_t;

    tsw_state_t s_r;
    tsw_state_t s_nxt;

    tsw_strap_t strap;
    logic       pulse_start;
    logic       pulse_active;
    logic [15:0] pulse_sel;

    // straps cross into clk_i through three stages
    tsw_strap_sync u_strap_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .pins_i  (strap_pins_i),
        .strap_o (strap)
    );

    // one shared timer: every pulsing channel opens for the same window
    tsw_term_pulse #(
        .CYCLES (PULSE_CYCLES)
    ) u_term_pulse (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .start_i  (pulse_start),
        .active_o (pulse_active)
    );

    // register image forced by the straps
    function automatic tsw_regs_t strap_image(input tsw_strap_t p);
        tsw_regs_t r;
        r = '0;
        r.high_speed_modes[POS_ENABLE]            = p.strap_switch_enable;
        r.high_speed_modes[POS_SOURCE +: 2]       = p.strap_source_select;
        r.auxiliary_modes[POS_ENABLE]             = 1'b1;
        r.auxiliary_modes[POS_MODE +: 2]          = AUX_MODE_QUAD;
        r.auxiliary_modes[POS_SOURCE +: 2]        = p.strap_source_select;
        r.receiver_settings[POS_TERM_ON]          = 1'b1;
        r.term_pulse_low                          = 8'h00;
        r.term_pulse_high                         = 8'h00;
        r.equalizer_low                           = {8{p.strap_eq_level}};
        r.equalizer_high                          = {8{p.strap_eq_level}};
        r.transmitter_settings[POS_PREEMPH +: 2]  = p.strap_preemph_level;
        r.transmitter_settings[POS_OUT_TERM]      = p.strap_out_term;
        r.transmitter_settings[POS_OUT_CUR]       = p.strap_out_current;
        return r;
    endfunction : strap_image

    // read mux; index is three bits so every index is mapped
    function automatic logic [7:0] read_reg(input tsw_regs_t r, input logic [2:0] idx);
        logic [7:0] d;
        d = 8'h00;
        case (idx)
            IDX_HS_MODES:    d = r.high_speed_modes;
            IDX_AUX_MODES:   d = r.auxiliary_modes;
            IDX_RX_SETTINGS: d = r.receiver_settings;
            IDX_PULSE_LO:    d = r.term_pulse_low;
            IDX_PULSE_HI:    d = r.term_pulse_high;
            IDX_EQ_LO:       d = r.equalizer_low;
            IDX_EQ_HI:       d = r.equalizer_high;
            IDX_TX_SETTINGS: d = r.transmitter_settings;
            default:         d = 8'h00;
        endcase
        return d;
    endfunction : read_reg

    // register write with reserved bits held at zero
    function automatic tsw_regs_t write_reg(
        input tsw_regs_t  r,
        input logic [2:0] idx,
        input logic [7:0] d
    );
        tsw_regs_t n;
        n = r;
        case (idx)
            IDX_HS_MODES: begin
                n.high_speed_modes = d & MASK_MODES;
            end
            IDX_AUX_MODES: begin
                n.auxiliary_modes = d & MASK_MODES;
                // illegal switching mode keeps the previous mode
                if (d[POS_MODE +: 2] == AUX_MODE_BAD) begin
                    n.auxiliary_modes[POS_MODE +: 2] = r.auxiliary_modes[POS_MODE +: 2];
                end
            end
            IDX_RX_SETTINGS: begin
                n.receiver_settings = d & MASK_RX;
            end
            IDX_PULSE_LO: begin
                n.term_pulse_low = d & MASK_FULL;
            end
            IDX_PULSE_HI: begin
                n.term_pulse_high = d & MASK_FULL;
            end
            IDX_EQ_LO: begin
                n.equalizer_low = d & MASK_FULL;
            end
            IDX_EQ_HI: begin
                n.equalizer_high = d & MASK_FULL;
            end
            IDX_TX_SETTINGS: begin
                n.transmitter_settings = d & MASK_TX;
            end
            default: begin
                n = r;
            end
        endcase
        return n;
    endfunction : write_reg

    always_comb begin
        s_nxt        = s_r;
        s_nxt.rvalid = 1'b0;

        // straps steer the map until the serial side first touches it
        if (s_r.pin_ctrl) begin
            s_nxt.regs = strap_image(strap);
        end

        // any access, read or write, ends strap control for good
        if (reg_wr_i || reg_rd_i) begin
            s_nxt.pin_ctrl = 1'b0;
        end

        // a write in the handover cycle wins over the strap image
        if (reg_wr_i) begin
            s_nxt.regs = write_reg(s_nxt.regs, reg_idx_i, reg_wdata_i);
        end

        // read answer the cycle after the strobe
        if (reg_rd_i) begin
            s_nxt.rdata  = read_reg(s_r.regs, reg_idx_i);
            s_nxt.rvalid = 1'b1;
        end

        // decoded controls
        s_nxt.hs_en    = s_r.regs.high_speed_modes[POS_ENABLE];
        s_nxt.hs_mode  = s_r.regs.high_speed_modes[POS_MODE +: 2];
        s_nxt.hs_src   = s_r.regs.high_speed_modes[POS_SOURCE +: 4];
        s_nxt.standby  = ~s_r.regs.high_speed_modes[POS_ENABLE];
        s_nxt.aux_en   = s_r.regs.auxiliary_modes[POS_ENABLE];
        s_nxt.aux_mode = s_r.regs.auxiliary_modes[POS_MODE +: 2];
        s_nxt.aux_src  = s_r.regs.auxiliary_modes[POS_SOURCE +: 4];

        // equalizer level per channel, 0 low and 1 high
        s_nxt.eq_level = tsw_chan_bits(s_r.regs.equalizer_low,
                                       s_r.regs.equalizer_high);

        // shared transmitter settings
        s_nxt.preemph  = s_r.regs.transmitter_settings[POS_PREEMPH +: 2];
        s_nxt.out_term = s_r.regs.transmitter_settings[POS_OUT_TERM];
        s_nxt.out_cur  = s_r.regs.transmitter_settings[POS_OUT_CUR];

        // remember the source to spot the next change
        s_nxt.src_prev = s_r.regs.high_speed_modes[POS_SOURCE +: 4];

        // termination: off when disabled, else open only where pulsing is selected
        if (!s_r.regs.receiver_settings[POS_TERM_ON]) begin
            s_nxt.term_conn = 16'h0000;
        end else begin
            s_nxt.term_conn = ~(pulse_sel & {16{pulse_active}});
        end
    end

    // channels with pulsing selected, in b a c d order
    assign pulse_sel   = tsw_chan_bits(s_r.regs.term_pulse_low, s_r.regs.term_pulse_high);

    // any change of the selected source restarts the open window
    assign pulse_start = (s_r.regs.high_speed_modes[POS_SOURCE +: 4] != s_r.src_prev);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r                           <= '0;
            s_r.regs.high_speed_modes     <= RST_HS_MODES;
            s_r.regs.auxiliary_modes      <= RST_AUX_MODES;
            s_r.regs.receiver_settings    <= RST_RX_SETTINGS;
            s_r.regs.term_pulse_low       <= RST_PULSE;
            s_r.regs.term_pulse_high      <= RST_PULSE;
            s_r.regs.equalizer_low        <= RST_EQ;
            s_r.regs.equalizer_high       <= RST_EQ;
            s_r.regs.transmitter_settings <= RST_TX_SETTINGS;
            s_r.pin_ctrl                  <= 1'b1;
            s_r.standby                   <= 1'b1;
            s_r.aux_en                    <= 1'b1;
            s_r.term_conn                 <= 16'hffff;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_o         = s_r.rdata;
    assign reg_rvalid_o        = s_r.rvalid;
    assign hs_switch_en_o      = s_r.hs_en;
    assign hs_mode_o           = s_r.hs_mode;
    assign hs_source_sel_o     = s_r.hs_src;
    assign standby_o           = s_r.standby;
    assign aux_switch_en_o     = s_r.aux_en;
    assign aux_mode_o          = s_r.aux_mode;
    assign aux_source_sel_o    = s_r.aux_src;
    assign input_term_conn_o   = s_r.term_conn;
    assign input_eq_level_o    = s_r.eq_level;
    assign out_preemph_level_o = s_r.preemph;
    assign out_term_on_o       = s_r.out_term;
    assign out_current_sel_o   = s_r.out_cur;
    assign pin_ctrl_o          = s_r.pin_ctrl;

endmodule : tsw_config_regs
`default_nettype wire

// File: hdl/tsw_pkg.sv
// shared constants, register map and carrier types of the switch configuration bank
package tsw_pkg;

    // register indices on the control port
    localparam logic [2:0] IDX_HS_MODES    = 3'h0;
    localparam logic [2:0] IDX_AUX_MODES   = 3'h1;
    localparam logic [2:0] IDX_RX_SETTINGS = 3'h2;
    localparam logic [2:0] IDX_PULSE_LO    = 3'h3;
    localparam logic [2:0] IDX_PULSE_HI    = 3'h4;
    localparam logic [2:0] IDX_EQ_LO       = 3'h5;
    localparam logic [2:0] IDX_EQ_HI       = 3'h6;
    localparam logic [2:0] IDX_TX_SETTINGS = 3'h7;

    // field positions
    localparam int unsigned POS_ENABLE     = 6;
    localparam int unsigned POS_MODE       = 4;
    localparam int unsigned POS_SOURCE     = 0;
    localparam int unsigned POS_TERM_ON    = 0;
    localparam int unsigned POS_PREEMPH    = 2;
    localparam int unsigned POS_OUT_TERM   = 1;
    localparam int unsigned POS_OUT_CUR    = 0;

    // writable bits; the rest are reserved and read zero
    localparam logic [7:0] MASK_MODES      = 8'h7f;
    localparam logic [7:0] MASK_RX         = 8'h01;
    localparam logic [7:0] MASK_FULL       = 8'hff;
    localparam logic [7:0] MASK_TX         = 8'h0f;

    localparam logic [1:0] AUX_MODE_QUAD   = 2'h0;
    localparam logic [1:0] AUX_MODE_BAD    = 2'h3;

    // reset values, overwritten by the straps from the first cycle on
    localparam logic [7:0] RST_HS_MODES    = 8'h00;
    localparam logic [7:0] RST_AUX_MODES   = 8'h40;
    localparam logic [7:0] RST_RX_SETTINGS = 8'h01;
    localparam logic [7:0] RST_PULSE       = 8'h00;
    localparam logic [7:0] RST_EQ          = 8'h00;
    localparam logic [7:0] RST_TX_SETTINGS = 8'h00;

    // termination pulse length
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned PULSE_MS       = 100;
    localparam int unsigned PULSE_CYC      = (CLK_HZ / 1000) * PULSE_MS;

    typedef struct packed {
        logic       strap_switch_enable;
        logic [1:0] strap_source_select;
        logic       strap_eq_level;
        logic [1:0] strap_preemph_level;
        logic       strap_out_term;
        logic       strap_out_current;
    } tsw_strap_t;

    typedef struct packed {
        logic [7:0] high_speed_modes;
        logic [7:0] auxiliary_modes;
        logic [7:0] receiver_settings;
        logic [7:0] term_pulse_low;
        logic [7:0] term_pulse_high;
        logic [7:0] equalizer_low;
        logic [7:0] equalizer_high;
        logic [7:0] transmitter_settings;
    } tsw_regs_t;

    // joins a low/high register pair into per-channel bits b0..b3 a0..a3 c3..c0 d3..d0
    function automatic logic [15:0] tsw_chan_bits(input logic [7:0] lo, input logic [7:0] hi);
        tsw_chan_bits = {hi, lo};
    endfunction : tsw_chan_bits

endpackage : tsw_pkg

// File: hdl/tsw_strap_sync.sv
// three-stage synchroniser with agreement filter for the strap pins
`timescale 1ns/1ps
`default_nettype none
module tsw_strap_sync
    import tsw_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // pins in, filtered value out
    input  wire tsw_strap_t pins_i,
    output var  tsw_strap_t strap_o
);

    typedef struct packed {
        tsw_strap_t s1;
        tsw_strap_t s2;
        tsw_strap_t s3;
        tsw_strap_t out;
    } tsw_sync_state_t;

    tsw_sync_state_t s_r;
    tsw_sync_state_t s_nxt;

    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = pins_i;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        // only stages two and three are compared; stage one may be metastable
        for (int i = 0; i < $bits(tsw_strap_t); i++) begin
            if (s_r.s2[i] == s_r.s3[i]) begin
                s_nxt.out[i] = s_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign strap_o = s_r.out;

endmodule : tsw_strap_sync
`default_nettype wire

// File: hdl/tsw_term_pulse.sv
// retriggerable timer holding input terminations open after a source change
`timescale 1ns/1ps
`default_nettype none
module tsw_term_pulse #(
    parameter int unsigned CYCLES = tsw_pkg::PULSE_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // start and status
    input  wire logic start_i,
    output var  logic active_o
);

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          active;
    } tsw_pulse_state_t;

    tsw_pulse_state_t s_r;
    tsw_pulse_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        // a new source change restarts the full open time
        if (start_i) begin
            s_nxt.cnt    = LOAD;
            s_nxt.active = 1'b1;
        end else if (s_r.active) begin
            if (s_r.cnt == '0) begin
                s_nxt.active = 1'b0;
            end else begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign active_o = s_r.active;

endmodule : tsw_term_pulse
`default_nettype wire

// File: tb/tb_top.sv
// self-checking testbench of the switch configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tsw_pkg::*;
;
    typedef struct packed {
        logic [2:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
    } tsw_tb_row_t;

    localparam int unsigned PCYC = 20;
    localparam tsw_strap_t  S1   = tsw_strap_t'(8'hda);
    localparam tsw_strap_t  S2   = tsw_strap_t'(8'h25);
    localparam logic [7:0]  IMG [8] = '{8'h01, 8'h41, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
    localparam tsw_tb_row_t ROWS [8] = '{
        '{IDX_HS_MODES, 8'hb1, 8'h31}, '{IDX_AUX_MODES, 8'hf2, 8'h42},
        '{IDX_RX_SETTINGS, 8'hff, 8'h01}, '{IDX_PULSE_LO, 8'ha5, 8'ha5},
        '{IDX_PULSE_HI, 8'h5a, 8'h5a}, '{IDX_EQ_LO, 8'h3c, 8'h3c},
        '{IDX_EQ_HI, 8'hc3, 8'hc3}, '{IDX_TX_SETTINGS, 8'hff, 8'h0f}};

    logic        clk_i = 1'b0;
    logic        srst_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [2:0]  reg_idx_i;
    logic [7:0]  reg_wdata_i;
    logic [7:0]  reg_rdata_o;
    logic        reg_rvalid_o;
    logic        hs_switch_en_o, standby_o, aux_switch_en_o, pin_ctrl_o;
    logic [1:0]  hs_mode_o, aux_mode_o, out_preemph_level_o;
    logic [3:0]  hs_source_sel_o, aux_source_sel_o;
    logic [15:0] input_term_conn_o, input_eq_level_o;
    logic        out_term_on_o, out_current_sel_o;
    tsw_strap_t  level, pins;
    int          err_total, compares, k, n;
    logic [15:0] seen;
    wire logic [15:0] ctl_w = {1'b0, hs_switch_en_o, standby_o, aux_switch_en_o, hs_mode_o,
                               aux_mode_o, hs_source_sel_o, aux_source_sel_o};
    wire logic [15:0] tx_w  = {12'h0, out_preemph_level_o, out_term_on_o, out_current_sel_o};

    always #12.5ns clk_i = ~clk_i;

    tsw_strap_board i_board (.level_i(level), .pins_o(pins));

    tsw_config_regs #(.PULSE_CYCLES(PCYC)) i_dut (
        .clk_i(clk_i), .srst_i(srst_i), .strap_pins_i(pins), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .hs_switch_en_o(hs_switch_en_o), .hs_mode_o(hs_mode_o), .hs_source_sel_o(hs_source_sel_o),
        .standby_o(standby_o), .aux_switch_en_o(aux_switch_en_o), .aux_mode_o(aux_mode_o),
        .aux_source_sel_o(aux_source_sel_o), .input_term_conn_o(input_term_conn_o),
        .input_eq_level_o(input_eq_level_o), .out_preemph_level_o(out_preemph_level_o),
        .out_term_on_o(out_term_on_o), .out_current_sel_o(out_current_sel_o),
        .pin_ctrl_o(pin_ctrl_o));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic tick(input int cyc);
        repeat (cyc) @(posedge clk_i);
        #2ns;
    endtask : tick

    // one idle cycle between accesses keeps each strobe a clean pulse
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        tick(1);
        reg_wr_i    = 1'b1;
        reg_idx_i   = idx;
        reg_wdata_i = d;
        tick(1);
        reg_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
        tick(1);
        reg_rd_i  = 1'b1;
        reg_idx_i = idx;
        tick(1);
        reg_rd_i = 1'b0;
        chk("rvalid", 16'h1, {15'h0, reg_rvalid_o});
        chk("rdata", {8'h0, exp}, {8'h0, reg_rdata_o});
    endtask : rd

    task automatic strap_chk(input tsw_strap_t s);
        logic [15:0] e;
        tick(1);
        level = s;
        tick(8);
        e = {1'b0, s.strap_switch_enable, ~s.strap_switch_enable, 1'b1, 4'h0,
             2'h0, s.strap_source_select, 2'h0, s.strap_source_select};
        chk("strap modes", e, ctl_w);
        chk("strap eq", {16{s.strap_eq_level}}, input_eq_level_o);
        chk("strap term", 16'hffff, input_term_conn_o);
        chk("strap tx", {12'h0, s.strap_preemph_level, s.strap_out_term, s.strap_out_current}, tx_w);
        chk("pin ctrl", 16'h1, {15'h0, pin_ctrl_o});
    endtask : strap_chk

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    initial begin
        #(25ns * 5000);
        $display("watchdog expired");
        err_total++;
        complete_run();
    end

    initial begin
        srst_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_idx_i = 3'h0;
        reg_wdata_i = 8'h00;
        level = S1;
        err_total = 0;
        compares = 0;
        tick(8);
        srst_i = 1'b0;
        strap_chk(S1);
        strap_chk(S2);
        for (k = 0; k < 8; k++) rd(k[2:0], IMG[k]);
        level = S1;
        tick(8);
        chk("straps ignored", 16'h0005, tx_w);
        $display("test straps done");
        // source kept as strapped so no open window overlaps the pulse bit writes
        for (k = 0; k < 8; k++) begin
            wr(ROWS[k].idx, ROWS[k].wd);
            rd(ROWS[k].idx, ROWS[k].rd);
        end
        chk("eq chans", 16'hc33c, input_eq_level_o);
        chk("modes", 16'h3c12, ctl_w);
        for (k = 0; k < 4; k++) begin
            wr(IDX_TX_SETTINGS, {4'h0, k[1:0], k[0], ~k[0]});
            tick(1);
            chk("tx", {12'h0, k[1:0], k[0], ~k[0]}, tx_w);
        end
        $display("test registers done");
        wr(IDX_PULSE_LO, 8'h01);
        wr(IDX_PULSE_HI, 8'h80);
        tick(PCYC + 10);
        chk("term idle", 16'hffff, input_term_conn_o);
        wr(IDX_HS_MODES, 8'h46);
        n = 0;
        seen = 16'hffff;
        for (k = 0; k < 40; k++) begin
            tick(1);
            if (input_term_conn_o !== 16'hffff) begin
                n++;
                seen = input_term_conn_o;
            end
        end
        chk("pulse chans", 16'h7ffe, seen);
        chk("pulse len", 16'h1, {15'h0, (n >= PCYC - 1 && n <= PCYC + 1)});
        wr(IDX_HS_MODES, 8'h46);
        tick(6);
        chk("no change", 16'hffff, input_term_conn_o);
        wr(IDX_RX_SETTINGS, 8'h00);
        tick(1);
        chk("term off", 16'h0000, input_term_conn_o);
        $display("test pulse done");
        srst_i = 1'b1;
        tick(4);
        chk("reset pins", 16'h1, {15'h0, pin_ctrl_o});
        chk("reset term", 16'hffff, input_term_conn_o);
        srst_i = 1'b0;
        strap_chk(S2);
        $display("test reset done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire

// File: tb/tsw_cfg_sva.sv
// assertion checker of the switch configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tsw_cfg_sva
    import tsw_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // register port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [2:0]  reg_idx_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rvalid_o,
    // decoded controls
    input  wire logic        hs_switch_en_o,
    input  wire logic [1:0]  hs_mode_o,
    input  wire logic [3:0]  hs_source_sel_o,
    input  wire logic        standby_o,
    input  wire logic        aux_switch_en_o,
    input  wire logic [1:0]  aux_mode_o,
    input  wire logic [3:0]  aux_source_sel_o,
    input  wire logic [15:0] input_term_conn_o,
    input  wire logic [15:0] input_eq_level_o,
    input  wire logic [1:0]  out_preemph_level_o,
    input  wire logic        out_term_on_o,
    input  wire logic        out_current_sel_o,
    input  wire logic        pin_ctrl_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    AST_RD_ANSWER: assert property (
        !$past(srst_i) |-> reg_rvalid_o == $past(reg_rd_i)) else $error("read answer late");
    AST_ACCESS_ENDS_PINS: assert property (
        (reg_wr_i || reg_rd_i) |=> !pin_ctrl_o) else $error("pin control kept after access");
    AST_PINS_STAY_OFF: assert property (
        !pin_ctrl_o |=> !pin_ctrl_o) else $error("pin control came back");
    AST_STANDBY: assert property (
        standby_o != hs_switch_en_o) else $error("standby not inverse of enable");
    AST_PIN_MODES: assert property (
        pin_ctrl_o |-> aux_switch_en_o && hs_mode_o == 2'h0 && aux_mode_o == 2'h0
        && hs_source_sel_o[3:2] == 2'h0 && aux_source_sel_o == hs_source_sel_o)
        else $error("strap mode image wrong");
    AST_PIN_TERM: assert property (
        pin_ctrl_o |-> input_term_conn_o == 16'hffff) else $error("termination pulsed on straps");
    AST_PIN_EQ: assert property (
        pin_ctrl_o |-> input_eq_level_o == {16{input_eq_level_o[0]}})
        else $error("strap eq not uniform");
    AST_TX_WRITE: assert property (
        reg_wr_i && reg_idx_i == IDX_TX_SETTINGS ##1 !(reg_wr_i && reg_idx_i == IDX_TX_SETTINGS)
        |=> {out_preemph_level_o, out_term_on_o, out_current_sel_o} == $past(reg_wdata_i[3:0], 2))
        else $error("tx controls do not follow write");
    AST_EQ_WRITE: assert property (
        reg_wr_i && reg_idx_i == IDX_EQ_LO ##1 !(reg_wr_i && reg_idx_i == IDX_EQ_LO)
        |=> input_eq_level_o[7:0] == $past(reg_wdata_i, 2)) else $error("eq does not follow write");
    AST_PULSE_CAUSE: assert property (
        $fell(&input_term_conn_o) && |input_term_conn_o
        |-> $past(hs_source_sel_o, 1) != $past(hs_source_sel_o, 2))
        else $error("termination opened without source change");
endmodule : tsw_cfg_sva

bind tsw_config_regs tsw_cfg_sva #(.PULSE_CYCLES(PULSE_CYCLES)) i_sva (
    .clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i), .reg_rvalid_o(reg_rvalid_o),
    .hs_switch_en_o(hs_switch_en_o), .hs_mode_o(hs_mode_o), .hs_source_sel_o(hs_source_sel_o),
    .standby_o(standby_o), .aux_switch_en_o(aux_switch_en_o), .aux_mode_o(aux_mode_o),
    .aux_source_sel_o(aux_source_sel_o), .input_term_conn_o(input_term_conn_o),
    .input_eq_level_o(input_eq_level_o), .out_preemph_level_o(out_preemph_level_o),
    .out_term_on_o(out_term_on_o), .out_current_sel_o(out_current_sel_o),
    .pin_ctrl_o(pin_ctrl_o));
`default_nettype wire

// File: tb/tsw_strap_board.sv
// board strap model driving the configuration pins
`timescale 1ns/1ps
`default_nettype none
module tsw_strap_board
    import tsw_pkg::*;
(
    // wanted levels
    input  wire tsw_strap_t level_i,
    // pins towards the device
    output var  tsw_strap_t pins_o
);
    // every pin tied hard to a rail, never left floating
    always_comb pins_o = level_i;
endmodule : tsw_strap_board
`default_nettype wire
